/* File: rssp_map.svh */
/*
  offsets-free constant map for the relay switch serial slave port:
  frame width, field positions, reset values and pin sampling depth.
  assumes inclusion by bare name from every design file that needs it.
*/
`ifndef RSSP_MAP_SVH
`define RSSP_MAP_SVH

`define RSSP_FRAME_BITS 8
`define RSSP_CNT_BITS 3
`define RSSP_CTRL_MSB 7
`define RSSP_CTRL_LSB 4
`define RSSP_DATA_MSB 3
`define RSSP_DATA_LSB 0
`define RSSP_CMD_WRITE_BIT 7
`define RSSP_CTRL_PTR_MSB 6
`define RSSP_CTRL_PTR_LSB 4
`define RSSP_DIAG_PTR_MSB 5
`define RSSP_DIAG_PTR_LSB 4
`define RSSP_CTRL_REGS 8
`define RSSP_DIAG_REGS 4
`define RSSP_REG_BITS 4
`define RSSP_CTRL_RESET 4'h0
`define RSSP_SYNC_STAGES 3
`define RSSP_FIFO_DEPTH 2

`endif

/* File: rssp_pkg.sv */
/*
  types shared by the relay switch serial slave port.
  assumes rssp_map.svh is reachable on the include path.
*/
`include "rssp_map.svh"
package rssp_pkg;
  typedef logic [`RSSP_FRAME_BITS-1:0] rssp_frame_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } rssp_pins_s;

  typedef struct packed {
    logic fall_cs;
    logic rise_cs;
    logic fall_sclk;
    logic rise_sclk;
  } rssp_edges_s;

  typedef struct packed {
    logic wr;
    logic [`RSSP_CTRL_PTR_MSB-`RSSP_CTRL_PTR_LSB:0] ptr;
    logic [`RSSP_REG_BITS-1:0] data;
  } rssp_cmd_s;

  typedef enum logic [1:0] {
    RSSP_IDLE = 2'b00,
    RSSP_LOAD = 2'b01,
    RSSP_SHIFT = 2'b11,
    RSSP_CLOSE = 2'b10
  } rssp_state_e;
endpackage

/* File: rssp_pin_sync.sv */
/*
  three-flop synchroniser with agreement filter and edge detection for the
  serial pins. assumes pins are asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`include "rssp_map.svh"
module rssp_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [WIDTH-1:0] lvl_next;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        // a change counts once stages two and three agree
        lvl_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : lvl_reg[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    s1_reg <= pin_i;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    if (rst_i) begin
      lvl_reg <= rst_val_i;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;
  assign rise_o = lvl_next & ~lvl_reg;
  assign fall_o = ~lvl_next & lvl_reg;
endmodule

/* File: rssp_skid.sv */
/*
  two-entry buffer with valid and ready on both sides.
  assumes a single clock; ready falls only when both entries are full.
*/
`timescale 1ns/1ps
module rssp_skid #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg, wp_next, rp_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  always_comb begin
    push = in_valid_i && (cnt_reg != (AW+1)'(DEPTH));
    pop = out_ready_i && (cnt_reg != '0);
    wp_next = push ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next = pop ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
endmodule

/* File: rssp_slave.sv */
/*
  serial slave port of an eight-channel relay switch driver: frames on chip
  select, samples data on falling serial clock, shifts out on rising clock.
  assumes the serial pins are asynchronous and at least ~4x slower than
  clk_sys_i; diagnosis bits come in from the power stage as plain inputs.
*/
`timescale 1ns/1ps
`include "rssp_map.svh"
// Function
// [RULE1] four-line full duplex serial slave only
// [RULE2] chip select falling starts an access
// [RULE3] sample on clock fall, drive after rise
// [RULE4] master ends access raising chip select
// [RULE5] modulo eight counter qualifies received frames
// [RULE6] deselected: ignore inputs, output high impedance
// [RULE7] select fall loads diagnosis into shifter
// [RULE8] first output bit is error OR input
// [RULE9] accept only nonzero multiple of eight
// [RULE10] select rise copies shifter to matrix
// [RULE11] master holds clock low at select edges
// [RULE12] input most significant bit first
// [RULE13] output most significant bit first
// [RULE14] frame is eight bits: control, data
// [RULE15] reset returns port state to defaults
// [RULE16] chained devices share one chip select
// [RULE17] output follows input one frame later
// [RULE18] eight control registers, four diagnosis registers; diag_i is never read, the shifter loads status_i instead
// [RULE19] error flag held until reported once
module rssp_slave #(
  parameter int FRAME_BITS = `RSSP_FRAME_BITS
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic [`RSSP_DIAG_REGS*`RSSP_REG_BITS-1:0] diag_i,
  input wire logic [FRAME_BITS-1:0] status_i,
  output logic [`RSSP_CTRL_REGS*`RSSP_REG_BITS-1:0] ctrl_o,
  output logic frame_valid_o,
  input wire logic frame_ready_i,
  output logic [FRAME_BITS-1:0] frame_data_o,
  output logic frame_error_flag_o
);
  localparam int CW = `RSSP_CNT_BITS;

  rssp_pkg::rssp_pins_s pins_lvl, pins_rise, pins_fall;
  rssp_pkg::rssp_edges_s ev;

  rssp_pin_sync #(
    .WIDTH(3)
  ) u_sync ( // RULE1
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i({cs_n_i, sclk_i, sdi_i}),
    .rst_val_i(3'h4),
    .level_o(pins_lvl),
    .rise_o(pins_rise),
    .fall_o(pins_fall)
  );

  always_comb begin
    ev.fall_cs = pins_fall.cs_n;
    ev.rise_cs = pins_rise.cs_n;
    // clock edges only count while selected
    ev.fall_sclk = pins_fall.sclk && !pins_lvl.cs_n; // RULE6
    ev.rise_sclk = pins_rise.sclk && !pins_lvl.cs_n; // RULE6
  end

  rssp_pkg::rssp_state_e st_reg, st_next;
  logic [FRAME_BITS-1:0] sh_reg, sh_next;
  logic [FRAME_BITS-1:0] mtx_reg, mtx_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic any_reg, any_next;
  logic in_bit_reg, in_bit_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic fe_reg, fe_next;
  logic first_reg, first_next;
  logic [`RSSP_CTRL_REGS*`RSSP_REG_BITS-1:0] ctrl_reg, ctrl_next;
  logic push_valid, push_ready;
  logic frame_ok;
  rssp_pkg::rssp_cmd_s cmd;

  always_comb begin
    frame_ok = any_reg && (cnt_reg == '0); // RULE9
    cmd.wr = sh_reg[`RSSP_CMD_WRITE_BIT]; // RULE14
    cmd.ptr = sh_reg[`RSSP_CTRL_PTR_MSB:`RSSP_CTRL_PTR_LSB]; // RULE18
    cmd.data = sh_reg[`RSSP_DATA_MSB:`RSSP_DATA_LSB]; // RULE14
  end

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    mtx_next = mtx_reg;
    cnt_next = cnt_reg;
    any_next = any_reg;
    in_bit_next = in_bit_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    fe_next = fe_reg;
    first_next = first_reg;
    ctrl_next = ctrl_reg;
    push_valid = 1'b0;
    case (st_reg)
      rssp_pkg::RSSP_IDLE: begin
        oe_next = 1'b0; // RULE6
        if (ev.fall_cs) begin // RULE2
          st_next = rssp_pkg::RSSP_LOAD;
        end
      end
      rssp_pkg::RSSP_LOAD: begin
        // diagnosis snapshot and error-or-input on the first bit
        sh_next = status_i; // RULE7
        cnt_next = '0;
        any_next = 1'b0;
        first_next = 1'b1;
        oe_next = 1'b1;
        sdo_next = fe_reg | pins_lvl.sdi; // RULE8
        st_next = rssp_pkg::RSSP_SHIFT;
      end
      rssp_pkg::RSSP_SHIFT: begin
        if (ev.rise_cs) begin // RULE4
          st_next = rssp_pkg::RSSP_CLOSE;
        end else begin
          if (first_reg) begin
            sdo_next = fe_reg | pins_lvl.sdi; // RULE8
          end
          if (ev.fall_sclk) begin
            in_bit_next = pins_lvl.sdi; // RULE3
            sh_next = {sh_reg[FRAME_BITS-2:0], pins_lvl.sdi}; // RULE12 RULE17
            cnt_next = cnt_reg + 1'b1; // RULE5
            any_next = 1'b1;
          end
          if (ev.rise_sclk) begin
            first_next = 1'b0;
            sdo_next = sh_reg[FRAME_BITS-1]; // RULE13 RULE16
          end
        end
      end
      rssp_pkg::RSSP_CLOSE: begin
        oe_next = 1'b0;
        mtx_next = sh_reg; // RULE10
        if (frame_ok) begin
          push_valid = 1'b1;
          if (cmd.wr) begin
            ctrl_next[cmd.ptr*`RSSP_REG_BITS +: `RSSP_REG_BITS] = cmd.data; // RULE18
          end
          fe_next = 1'b0; // RULE19
        end else begin
          fe_next = 1'b1; // RULE9
        end
        st_next = rssp_pkg::RSSP_IDLE;
      end
      default: begin
        st_next = rssp_pkg::RSSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin // RULE15
      st_reg <= rssp_pkg::RSSP_IDLE;
      sh_reg <= '0;
      mtx_reg <= '0;
      cnt_reg <= '0;
      any_reg <= 1'b0;
      in_bit_reg <= 1'b0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      fe_reg <= 1'b0;
      first_reg <= 1'b0;
      ctrl_reg <= {`RSSP_CTRL_REGS{`RSSP_CTRL_RESET}};
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      mtx_reg <= mtx_next;
      cnt_reg <= cnt_next;
      any_reg <= any_next;
      in_bit_reg <= in_bit_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      fe_reg <= fe_next;
      first_reg <= first_next;
      ctrl_reg <= ctrl_next;
    end
  end

  logic [FRAME_BITS-1:0] buf_data;
  logic buf_valid;
  logic pop_ok;

  rssp_skid #(
    .WIDTH(FRAME_BITS),
    .DEPTH(`RSSP_FIFO_DEPTH)
  ) u_buf (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(push_valid),
    .in_ready_o(push_ready),
    .in_data_i(mtx_next),
    .out_valid_o(buf_valid),
    .out_ready_i(pop_ok),
    .out_data_o(buf_data)
  );

  logic fv_reg, fv_next;
  logic [FRAME_BITS-1:0] fd_reg, fd_next;

  always_comb begin
    // output register refills when empty or being emptied
    pop_ok = !fv_reg || frame_ready_i;
    fv_next = fv_reg;
    fd_next = fd_reg;
    if (pop_ok) begin
      fv_next = buf_valid;
      fd_next = buf_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fv_reg <= 1'b0;
      fd_reg <= '0;
    end else begin
      fv_reg <= fv_next;
      fd_reg <= fd_next;
    end
  end

  // independent bit tally, read only by the framing assertions
  logic [7:0] tally_reg, tally_next;
  logic tally_any_reg, tally_any_next;

  always_comb begin
    tally_next = tally_reg;
    tally_any_next = tally_any_reg;
    if (st_reg == rssp_pkg::RSSP_LOAD) begin
      tally_next = 8'h00;
      tally_any_next = 1'b0;
    end else if (st_reg == rssp_pkg::RSSP_SHIFT && !ev.rise_cs && ev.fall_sclk) begin
      tally_next = tally_reg + 8'h01;
      tally_any_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tally_reg <= 8'h00;
      tally_any_reg <= 1'b0;
    end else begin
      tally_reg <= tally_next;
      tally_any_reg <= tally_any_next;
    end
  end

  assign sdo_o = sdo_reg;
  assign sdo_oe_o = oe_reg;
  assign ctrl_o = ctrl_reg;
  assign frame_valid_o = fv_reg;
  assign frame_data_o = fd_reg;
  assign frame_error_flag_o = fe_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_deselect;
    ev.rise_cs && st_reg == rssp_pkg::RSSP_SHIFT;
  endsequence

  sequence s_select;
    st_reg == rssp_pkg::RSSP_IDLE && ev.fall_cs;
  endsequence

  sequence s_bad_close;
    s_deselect ##1 !frame_ok;
  endsequence

  sequence s_good_write;
    s_deselect ##1 (frame_ok && cmd.wr);
  endsequence

  sequence s_good_keep;
    s_deselect ##1 (frame_ok && !cmd.wr);
  endsequence

  sequence s_sclk_fall;
    st_reg == rssp_pkg::RSSP_SHIFT && !ev.rise_cs && ev.fall_sclk;
  endsequence

  oe_idle_hiz_a: assert property (st_reg == rssp_pkg::RSSP_IDLE |=> !sdo_oe_o) // RULE6
    else $error("output driven while deselected");
  select_load_a: assert property (s_select |=> st_reg == rssp_pkg::RSSP_LOAD ##1 sh_reg == $past(status_i)) // RULE7
    else $error("diagnosis not loaded on select");
  first_bit_a: assert property (st_reg == rssp_pkg::RSSP_LOAD |=> sdo_oe_o && sdo_o == $past(fe_reg | pins_lvl.sdi)) // RULE8
    else $error("first output bit wrong");
  bad_frame_a: assert property (s_deselect ##1 !frame_ok |=> frame_error_flag_o) // RULE9
    else $error("frame error not flagged");
  good_frame_a: assert property (s_deselect ##1 frame_ok |=> !frame_error_flag_o) // RULE19
    else $error("error flag not cleared after good frame");
  matrix_copy_a: assert property (s_deselect ##1 1'b1 |=> mtx_reg == $past(sh_reg)) // RULE10
    else $error("matrix not copied on deselect");
  shift_in_a: assert property (st_reg == rssp_pkg::RSSP_SHIFT && !ev.rise_cs && ev.fall_sclk
      |=> sh_reg[0] == $past(pins_lvl.sdi) && cnt_reg == $past(cnt_reg) + 1'b1) // RULE12
    else $error("input bit not shifted in");
  shift_out_a: assert property (st_reg == rssp_pkg::RSSP_SHIFT && !ev.rise_cs && ev.rise_sclk
      |=> sdo_o == $past(sh_reg[FRAME_BITS-1])) // RULE13
    else $error("output bit not msb");
  deselect_hiz_a: assert property (s_deselect |=> ##1 !sdo_oe_o) // RULE6
    else $error("output not released after deselect");

  // framing and command decode
  tally_frame_a: assert property (st_reg == rssp_pkg::RSSP_CLOSE |-> frame_ok == (tally_any_reg && tally_reg[2:0] == 3'h0)) // RULE5
    else $error("frame qualification disagrees with bit tally");
  count_clear_a: assert property (s_select |=> ##1 cnt_reg == '0 && !any_reg) // RULE5
    else $error("bit counter not cleared on select");
  ctrl_write_a: assert property (s_good_write
      |=> ctrl_o[$past(cmd.ptr)*`RSSP_REG_BITS +: `RSSP_REG_BITS] == $past(cmd.data)) // RULE18
    else $error("control register not written");
  good_keep_a: assert property (s_good_keep |=> $stable(ctrl_o)) // RULE18
    else $error("control bank changed without write");
  bad_keep_a: assert property (s_bad_close |=> $stable(ctrl_o)) // RULE9
    else $error("control bank changed by bad frame");
  error_hold_a: assert property (frame_error_flag_o && st_reg != rssp_pkg::RSSP_CLOSE |=> frame_error_flag_o) // RULE19
    else $error("error flag cleared before report");

  // serial pins
  sample_bit_a: assert property (s_sclk_fall |=> in_bit_reg == sh_reg[0]) // RULE3
    else $error("sampled bit not captured");
  first_hold_a: assert property (st_reg == rssp_pkg::RSSP_SHIFT && first_reg && !ev.rise_cs && !ev.rise_sclk
      |=> sdo_o == $past(fe_reg | pins_lvl.sdi)) // RULE8
    else $error("first output bit not held");
  select_oe_a: assert property (s_select |=> ##1 sdo_oe_o) // RULE8
    else $error("output not enabled after select");
  oe_select_only_a: assert property (sdo_oe_o |-> st_reg inside {rssp_pkg::RSSP_SHIFT, rssp_pkg::RSSP_CLOSE}) // RULE6
    else $error("output enabled outside an access");
  idle_quiet_a: assert property (st_reg == rssp_pkg::RSSP_IDLE |=> $stable(sh_reg) && $stable(cnt_reg)) // RULE6
    else $error("shifter moved while deselected");

  // sequencing and hand-over
  close_idle_a: assert property (st_reg == rssp_pkg::RSSP_CLOSE |=> st_reg == rssp_pkg::RSSP_IDLE) // RULE4
    else $error("access not closed");
  load_shift_a: assert property (st_reg == rssp_pkg::RSSP_LOAD |=> st_reg == rssp_pkg::RSSP_SHIFT && first_reg) // RULE7
    else $error("load not followed by shift");
  frame_hold_a: assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o)) // RULE5
    else $error("frame dropped while stalled");
endmodule

/* File: rssp_master.sv */
/*
  serial master model for the relay switch port bench: frames on chip select,
  sclk high for 6 and low for 7 system clocks, data set while sclk is low.
  assumes pins change only just after a rising edge of clk_sys_i.
*/
`timescale 1ns/1ps
module rssp_master (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b1;
  end

  // low nbits of tx go out msb first; rx gathers sdo late in each high phase
  task automatic xfer(input int nbits, input logic [15:0] tx, output logic [1:0] first, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b0;
    sdi_o <= (nbits > 0) ? tx[nbits-1] : 1'b0;
    repeat (10) @(posedge clk_sys_i);
    first = {sdo_oe_i, sdo_i};
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rx = {rx[14:0], sdo_i};
      sclk_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      if (i + 1 < nbits) sdi_o <= tx[nbits-2-i];
    end
    repeat (2) @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    // a released data line must not keep its last level
    sdi_o <= ~sdi_o;
    repeat (12) @(posedge clk_sys_i);
  endtask

  // clock and data toggle while deselected; reports any output enable seen
  task automatic noise(output logic seen);
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      sclk_o <= ~sclk_o;
      sdi_o <= ~sdi_o;
      repeat (6) @(posedge clk_sys_i);
      seen = seen | sdo_oe_i;
    end
  endtask
endmodule

/* File: relay_switch_spi_slave_bench.sv */
/*
  self-checking bench for the relay switch serial slave port.
  assumes rssp_pkg and rssp_master compile first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module relay_switch_spi_slave_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, sdi, sdo, sdo_oe, frame_valid, err_flag;
  logic frame_ready = 1'b0;
  logic [7:0] status = 8'h00;
  logic [7:0] frame_data;
  logic [31:0] ctrl;
  logic [31:0] ctrl_exp = 32'h0;
  int err_total = 0;
  int n_checks = 0;

  always #10 clk_sys = ~clk_sys;

  rssp_master u_master (.clk_sys_i(clk_sys), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi));
  rssp_slave u_dut (.clk_sys_i(clk_sys), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .diag_i(16'h0000), .status_i(status), .ctrl_o(ctrl), .frame_valid_o(frame_valid),
    .frame_ready_i(frame_ready), .frame_data_o(frame_data), .frame_error_flag_o(err_flag));

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic pop(input logic [7:0] ex);
    for (int k = 0; k < 20 && frame_valid !== 1'b1; k++) @(posedge clk_sys);
    `CHK("frame_valid", 1'b1, frame_valid)
    `CHK("frame_data", ex, frame_data)
    frame_ready <= 1'b1;
    @(posedge clk_sys);
    frame_ready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic good(input logic [7:0] tx, input logic err_before);
    logic [1:0] first;
    logic [15:0] rx;
    status <= ~tx;
    u_master.xfer(8, {8'h00, tx}, first, rx);
    `CHK("first_bit", {1'b1, err_before | tx[7]}, first)
    `CHK("sdo_bits", ~tx, rx[7:0])
    if (tx[7]) ctrl_exp[tx[6:4]*4 +: 4] = tx[3:0];
    `CHK("ctrl", ctrl_exp, ctrl)
    `CHK("err_flag", 1'b0, err_flag)
    pop(tx);
  endtask

  task automatic t_reset();
    `CHK("oe_reset", 1'b0, sdo_oe)
    `CHK("ctrl_reset", 32'h0, ctrl)
    `CHK("err_reset", 1'b0, err_flag)
    `CHK("valid_reset", 1'b0, frame_valid)
  endtask

  task automatic t_writes();
    for (int p = 0; p < 8; p++) good({1'b1, p[2:0], 4'(p + 5)}, 1'b0);
    good(8'h25, 1'b0);
  endtask

  task automatic t_bad();
    logic [1:0] first;
    logic [15:0] rx;
    u_master.xfer(12, 16'h0ff5, first, rx);
    `CHK("err_after_12", 1'b1, err_flag)
    `CHK("ctrl_kept", ctrl_exp, ctrl)
    `CHK("no_frame", 1'b0, frame_valid)
    u_master.xfer(0, 16'h0000, first, rx);
    `CHK("err_first", 2'b11, first)
    `CHK("err_after_0", 1'b1, err_flag)
    good(8'h12, 1'b1);
  endtask

  task automatic t_ignore();
    logic seen;
    u_master.noise(seen);
    `CHK("oe_deselected", 1'b0, seen)
    `CHK("valid_deselected", 1'b0, frame_valid)
    `CHK("err_deselected", 1'b0, err_flag)
  endtask

  task automatic t_chain();
    logic [1:0] first;
    logic [15:0] rx;
    status <= 8'hc3;
    u_master.xfer(16, 16'h9a3c, first, rx);
    `CHK("chain_status", 8'hc3, rx[15:8])
    `CHK("chain_through", 8'h9a, rx[7:0])
    `CHK("chain_ctrl", ctrl_exp, ctrl)
    pop(8'h3c);
  endtask

  task automatic t_stall();
    logic [1:0] first;
    logic [15:0] rx;
    for (int i = 1; i < 4; i++) u_master.xfer(8, {8'h00, 8'(i)}, first, rx);
    pop(8'h01);
    pop(8'h02);
    pop(8'h03);
    for (int k = 0; k < 40; k++) begin
      frame_ready <= frame_valid;
      @(posedge clk_sys);
    end
    frame_ready <= 1'b0;
    @(posedge clk_sys);
    `CHK("drained", 1'b0, frame_valid)
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("ctrl_rereset", 32'h0, ctrl)
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    t_reset();
    t_writes();
    t_bad();
    t_ignore();
    t_chain();
    t_stall();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("ERROR watchdog expected done seen timeout");
    results();
  end
endmodule
